// ==== include/sct_pkg.sv ====
// Constants, field layout and types shared by the elapsed-time counter
package sct_pkg;

  // ------------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PRES_W = 16;
  localparam int unsigned FLAG_W = 2;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_ALARM = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_VALUE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0C;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [DATA_W-1:0] MODE_RESET = 32'h0000_8000;
  localparam logic [DATA_W-1:0] ALARM_RESET = 32'hFFFF_FFFF;
  localparam logic [DATA_W-1:0] VALUE_RESET = 32'h0000_0000;
  localparam logic [FLAG_W-1:0] STATUS_RESET = 2'h0;
  localparam logic [PRES_W-1:0] PRES_RESET = MODE_RESET[PRES_W-1:0];

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int unsigned PRES_LSB = 0;
  localparam int unsigned ALM_IEN_BIT = 16;
  localparam int unsigned INC_IEN_BIT = 17;
  localparam int unsigned RESTART_BIT = 18;
  localparam int unsigned ST_ALARM_BIT = 0;
  localparam int unsigned ST_INC_BIT = 1;

  // ------------------------------------------------------------------
  // Arithmetic constants
  // ------------------------------------------------------------------
  localparam logic [PRES_W-1:0] PRES_ONE = 16'h0001;
  localparam logic [DATA_W-1:0] COUNT_ONE = 32'h0000_0001;

  // ------------------------------------------------------------------
  // Delayed-action tracker: waits two slow clock edges
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    SCT_W_IDLE,
    SCT_W_FIRST,
    SCT_W_SECOND
  } sct_wait_e;

endpackage

// ==== design/sct_prescaler.sv ====
// Programmable slow clock divider producing the counter advance pulse
`timescale 1ns/10ps

module sct_prescaler
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic slow_tick,
  input wire logic reload,
  input wire logic [sct_pkg::PRES_W-1:0] prescale_value,
  output logic inc_tick
);
  import sct_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [PRES_W-1:0] period_q;
  logic [PRES_W-1:0] period_d;
  logic [PRES_W-1:0] div_q;
  logic [PRES_W-1:0] div_d;
  logic tick_q;
  logic tick_d;
  logic [PRES_W-1:0] terminal;

  // Period is latched only on reload, so a mode write alone never
  // disturbs a running division
  always_comb
  begin
    terminal = period_q - PRES_ONE; // Zero wraps to 65535: 2^16 period
    period_d = period_q;
    div_d = div_q;
    tick_d = 1'b0;
    if (reload)
    begin
      period_d = prescale_value; // Restart with the new setting
      div_d = '0;
    end
    else if (slow_tick)
    begin
      if (div_q == terminal)
      begin
        div_d = '0;
        tick_d = 1'b1; // One advance per N slow periods
      end
      else
      begin
        div_d = div_q + PRES_ONE;
      end
    end
  end

  // Divider registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      period_q <= PRES_RESET;
      div_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      period_q <= period_d;
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  assign inc_tick = tick_q;

endmodule // sct_prescaler

// ==== design/sct_elapsed_counter.sv ====
// Elapsed-time counter: register port, counter, alarm and interrupt
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps

// What this block does
// - Reset: mode 0x8000, alarm all ones, value and status zero.
// - Prescale zero advances the counter every 65536 slow periods.
// - Nonzero prescale N advances the counter every N slow periods.
// - Mode bit 16 lets the alarm flag raise the interrupt.
// - Mode bit 17 lets the increment flag raise the interrupt.
// - Mode bit 18 written one reloads the divider, clears the counter.
// - Alarm fires when the counter reaches alarm value plus one.
// - Value register read returns the count with no side effect.
// - Alarm flag, status bit 0, stays set until status is read.
// - Increment flag, status bit 1, set on each advance until read.
// - A status read clears both flags.
// - Restart and flag clear act two slow clock edges after access.
// - The 32-bit counter counts up and wraps to zero.

module sct_elapsed_counter
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic slow_clk_in,
  input wire logic [sct_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sct_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [sct_pkg::DATA_W-1:0] reg_rdata,
  output logic irq
);
  import sct_pkg::*;

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic slow_prev_q;
  logic slow_prev_d;
  logic slow_tick;

  sct_wait_e restart_wait_q;
  sct_wait_e restart_wait_d;
  sct_wait_e clear_wait_q;
  sct_wait_e clear_wait_d;
  logic restart_req;
  logic clear_req;
  logic restart_fire;
  logic clear_fire;

  logic [PRES_W-1:0] prescale_value_q;
  logic [PRES_W-1:0] prescale_value_d;
  logic alarm_irq_enable_q;
  logic alarm_irq_enable_d;
  logic increment_irq_enable_q;
  logic increment_irq_enable_d;
  logic [DATA_W-1:0] alarm_value_q;
  logic [DATA_W-1:0] alarm_value_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  logic [DATA_W-1:0] current_count_q;
  logic [DATA_W-1:0] current_count_d;
  logic [FLAG_W-1:0] status_q;
  logic [FLAG_W-1:0] status_d;
  logic [DATA_W-1:0] count_next;
  logic [DATA_W-1:0] alarm_target;
  logic alarm_hit;
  logic advance;
  logic inc_tick;
  logic wr_mode;
  logic wr_alarm;
  logic [FLAG_W-1:0] irq_enable;

  // ------------------------------------------------------------------
  // Two-edge wait tracker
  // ------------------------------------------------------------------

  // A fresh request restarts the wait; the action falls on the second
  // slow edge seen after the last request
  function automatic sct_wait_e wait_next(
    input sct_wait_e cur,
    input logic start,
    input logic tick
  );
    sct_wait_e nxt;
    nxt = cur;
    if (start)
    begin
      nxt = SCT_W_FIRST;
    end
    else if (tick)
    begin
      unique case (cur)
        SCT_W_IDLE: nxt = SCT_W_IDLE;
        SCT_W_FIRST: nxt = SCT_W_SECOND;
        SCT_W_SECOND: nxt = SCT_W_IDLE;
        default: nxt = SCT_W_IDLE;
      endcase
    end
    return nxt;
  endfunction

  // ------------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------------

  // Strobes are one cycle and never overlap, so plain decode suffices
  assign wr_mode = reg_wr && (reg_addr == OFF_MODE);
  assign wr_alarm = reg_wr && (reg_addr == OFF_ALARM);
  assign restart_req = wr_mode && reg_wdata[RESTART_BIT];
  assign clear_req = reg_rd && (reg_addr == OFF_STATUS);

  // ------------------------------------------------------------------
  // Slow clock edge and delayed actions
  // ------------------------------------------------------------------

  // The slow clock is sampled as an ordinary synchronous input, so the
  // count and flags live in the core clock and never tear when read
  always_comb
  begin
    slow_prev_d = slow_clk_in;
    slow_tick = slow_clk_in && !slow_prev_q;
    restart_wait_d = wait_next(restart_wait_q, restart_req, slow_tick);
    clear_wait_d = wait_next(clear_wait_q, clear_req, slow_tick);
    // Fire on the second slow edge after the access
    restart_fire = (restart_wait_q == SCT_W_SECOND) && slow_tick
                   && !restart_req;
    clear_fire = (clear_wait_q == SCT_W_SECOND) && slow_tick
                 && !clear_req;
  end

  // Edge detector and wait trackers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slow_prev_q <= 1'b0;
      restart_wait_q <= SCT_W_IDLE;
      clear_wait_q <= SCT_W_IDLE;
    end
    else
    begin
      slow_prev_q <= slow_prev_d;
      restart_wait_q <= restart_wait_d;
      clear_wait_q <= clear_wait_d;
    end
  end

  // ------------------------------------------------------------------
  // Divider
  // ------------------------------------------------------------------

  // The divider takes the prescale held at reload time, which is the
  // value written with the restart request unless rewritten meanwhile
  sct_prescaler u_prescaler
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .slow_tick(slow_tick),
    .reload(restart_fire),
    .prescale_value(prescale_value_q),
    .inc_tick(inc_tick)
  );

  // ------------------------------------------------------------------
  // Counter, alarm and status flags
  // ------------------------------------------------------------------

  // Restart beats a pending advance; a flag set beats a clear in the
  // same cycle so no event is dropped at that instant
  always_comb
  begin
    advance = inc_tick && !restart_fire;
    count_next = current_count_q + COUNT_ONE; // Wraps past max
    alarm_target = alarm_value_q + COUNT_ONE;
    // Edge-like hit: only on the advance that lands on the target, so
    // a count parked on it does not refill the flag after a clear
    alarm_hit = advance && (count_next == alarm_target);
    current_count_d = current_count_q;
    if (restart_fire)
    begin
      current_count_d = '0;
    end
    else if (advance)
    begin
      current_count_d = count_next;
    end
    status_d = status_q;
    if (clear_fire)
    begin
      status_d = '0;
    end
    if (alarm_hit)
    begin
      status_d[ST_ALARM_BIT] = 1'b1; // Sticky until read
    end
    if (advance)
    begin
      status_d[ST_INC_BIT] = 1'b1; // Sticky until read
    end
  end

  // Counter and flag registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      current_count_q <= VALUE_RESET;
      status_q <= STATUS_RESET;
    end
    else
    begin
      current_count_q <= current_count_d;
      status_q <= status_d;
    end
  end

  // ------------------------------------------------------------------
  // Registers and read data
  // ------------------------------------------------------------------

  // The restart bit is a command and is not stored; it reads as zero
  always_comb
  begin
    prescale_value_d = prescale_value_q;
    alarm_irq_enable_d = alarm_irq_enable_q;
    increment_irq_enable_d = increment_irq_enable_q;
    alarm_value_d = alarm_value_q;
    if (wr_mode)
    begin
      prescale_value_d = reg_wdata[PRES_LSB +: PRES_W];
      alarm_irq_enable_d = reg_wdata[ALM_IEN_BIT];
      increment_irq_enable_d = reg_wdata[INC_IEN_BIT];
    end
    if (wr_alarm)
    begin
      alarm_value_d = reg_wdata;
    end
    rdata_d = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        OFF_MODE:
        begin
          rdata_d[PRES_LSB +: PRES_W] = prescale_value_q;
          rdata_d[ALM_IEN_BIT] = alarm_irq_enable_q;
          rdata_d[INC_IEN_BIT] = increment_irq_enable_q;
        end
        OFF_ALARM: rdata_d = alarm_value_q;
        OFF_VALUE: rdata_d = current_count_q; // No side effect
        OFF_STATUS: rdata_d[FLAG_W-1:0] = status_q;
        default: rdata_d = '0; // Unmapped reads return zero
      endcase
    end
  end

  // Software-visible registers; read data stand for one cycle only
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prescale_value_q <= PRES_RESET;
      alarm_irq_enable_q <= MODE_RESET[ALM_IEN_BIT];
      increment_irq_enable_q <= MODE_RESET[INC_IEN_BIT];
      alarm_value_q <= ALARM_RESET;
      rdata_q <= '0;
    end
    else
    begin
      prescale_value_q <= prescale_value_d;
      alarm_irq_enable_q <= alarm_irq_enable_d;
      increment_irq_enable_q <= increment_irq_enable_d;
      alarm_value_q <= alarm_value_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ------------------------------------------------------------------
  // Interrupt
  // ------------------------------------------------------------------

  // Enables line up with the status layout; a handler should drop the
  // enable, since flags linger two slow edges after the read
  always_comb
  begin
    irq_enable = '0;
    irq_enable[ST_ALARM_BIT] = alarm_irq_enable_q;
    irq_enable[ST_INC_BIT] = increment_irq_enable_q;
    irq = |(status_q & irq_enable);
  end

endmodule // sct_elapsed_counter

// ==== verification/sct_elapsed_counter_assertions.sv ====
// Port-level checker for the elapsed-time counter
`timescale 1ns/10ps

module sct_elapsed_counter_checker
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic slow_clk_in,
  input wire logic [sct_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sct_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [sct_pkg::DATA_W-1:0] reg_rdata,
  input wire logic irq
);
  import sct_pkg::*;
  logic [31:0] mode_q, mode_d, alarm_q, alarm_d;

  // ------------------------------------------------------------------
  // Shadow registers
  // ------------------------------------------------------------------
  // Restart bit is dropped: it is a command and never reads back
  always_comb
  begin
    mode_d = mode_q;
    alarm_d = alarm_q;
    if (reg_wr && reg_addr == OFF_MODE)
      mode_d = reg_wdata & 32'h0003_FFFF;
    if (reg_wr && reg_addr == OFF_ALARM)
      alarm_d = reg_wdata;
  end

  // Shadows start from the documented reset values
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= MODE_RESET;
      alarm_q <= ALARM_RESET;
    end
    else
    begin
      mode_q <= mode_d;
      alarm_q <= alarm_d;
    end
  end

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_RD_MODE: assert property (reg_rd && reg_addr == OFF_MODE
    |=> reg_rdata == mode_q) else $error("mode readback wrong");
  AST_RD_ALARM: assert property (reg_rd && reg_addr == OFF_ALARM
    |=> reg_rdata == alarm_q) else $error("alarm readback wrong");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  AST_RD_UNMAP: assert property (reg_rd && reg_addr > OFF_STATUS
    |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
  AST_ST_UPPER: assert property (reg_rd && reg_addr == OFF_STATUS
    |=> reg_rdata[31:2] == 30'h0) else $error("status spare bits set");
  AST_IRQ_MIX: assert property (reg_rd && reg_addr == OFF_STATUS
    |=> $past(irq) == ((reg_rdata[0] & $past(mode_q[16]))
      | (reg_rdata[1] & $past(mode_q[17])))) else $error("irq mix wrong");
  AST_IRQ_ALM: assert property (irq && !mode_q[17] |-> mode_q[16])
    else $error("irq with alarm enable clear");
  AST_IRQ_INC: assert property (irq && !mode_q[16] |-> mode_q[17])
    else $error("irq with increment enable clear");
  AST_RST_IRQ: assert property ($rose(rst_n) |-> !irq)
    else $error("irq high after reset");

  cover property (reg_wr && reg_addr == OFF_MODE && reg_wdata[18]);
  cover property (reg_rd && reg_addr == OFF_STATUS ##1 reg_rdata[0]);
  cover property ($rose(irq));
endmodule // sct_elapsed_counter_checker

bind sct_elapsed_counter sct_elapsed_counter_checker
  sct_elapsed_counter_checker_inst (.core_clk(core_clk), .rst_n(rst_n),
  .slow_clk_in(slow_clk_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

// ==== verification/tb_top.sv ====
// Self-checking testbench for the elapsed-time counter
`timescale 1ns/10ps

module tb_top;
  import sct_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow_clk_in = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, rv, v1;
  logic irq;
  int miscompares = 0;
  int tests_run = 0;
  int pres_tab[3] = '{1, 3, 5};

  sct_elapsed_counter sct_elapsed_counter_inst (.core_clk(core_clk),
    .rst_n(rst_n), .slow_clk_in(slow_clk_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));

  // 100 MHz core clock
  always #5 core_clk = ~core_clk;

  // ------------------------------------------------------------------
  // Bus, slow clock and compare helpers
  // ------------------------------------------------------------------
  task automatic chk(
    input string w,
    input logic [31:0] e,
    input logic [31:0] g
  );
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data is valid only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Slow clock only toggles here, so tick counts are exact
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      slow_clk_in <= 1'b1;
      @(posedge core_clk);
      slow_clk_in <= 1'b0;
    end
    repeat (3) @(posedge core_clk);
  endtask
  // Restart lands two slow ticks after the write
  task automatic restart(input logic [15:0] p, input logic [1:0] en);
    wr(OFF_MODE, {13'h0, 1'b1, en, p});
    tick(2);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    rd(OFF_MODE, rv);
    chk("mode", MODE_RESET, rv);
    rd(OFF_ALARM, rv);
    chk("alarm", ALARM_RESET, rv);
    rd(OFF_VALUE, rv);
    chk("value", VALUE_RESET, rv);
    rd(OFF_STATUS, rv);
    chk("status", 32'h0, rv);
    rd(8'h10, rv);
    chk("unmapped", 32'h0, rv);
    $display("test reset done");
  endtask
  // Any 15 ticks hold exactly 15/N divider periods
  task automatic t_rate();
    foreach (pres_tab[i])
    begin
      restart(pres_tab[i][15:0], 2'b00);
      rd(OFF_VALUE, v1);
      chk("restart value", 32'h0, v1);
      tick(15);
      rd(OFF_VALUE, rv);
      chk("advance", 32'(15 / pres_tab[i]), rv);
    end
    restart(16'h0000, 2'b00);
    tick(300);
    rd(OFF_VALUE, rv);
    chk("zero prescale", 32'h0, rv);
    $display("test rate done");
  endtask
  task automatic t_status();
    restart(16'h000A, 2'b10);
    rd(OFF_STATUS, rv);
    tick(14);
    chk("inc irq", 32'h1, {31'h0, irq});
    rd(OFF_STATUS, rv);
    chk("inc flag", 32'h2, rv);
    rd(OFF_STATUS, rv);
    chk("clear delayed", 32'h2, rv);
    wr(OFF_MODE, {16'h0, 16'h000A});
    #1 chk("inc irq off", 32'h0, {31'h0, irq});
    tick(2);
    rd(OFF_STATUS, rv);
    chk("flags cleared", 32'h0, rv);
    $display("test status done");
  endtask
  task automatic t_alarm();
    wr(OFF_ALARM, 32'h0000_0009);
    // Count is still 1 from the status test: the restart must wait
    wr(OFF_MODE, {13'h0, 1'b1, 2'b01, 16'h0001});
    tick(1);
    rd(OFF_VALUE, rv);
    chk("restart pending", 32'h0000_0001, rv);
    tick(1);
    rd(OFF_VALUE, rv);
    chk("restart landed", 32'h0, rv);
    for (int k = 0; k < 12 && rv != 32'h0000_000A; k++)
    begin
      chk("early irq", 32'h0, {31'h0, irq});
      tick(1);
      rd(OFF_VALUE, rv);
    end
    chk("alarm point", 32'h0000_000A, rv);
    tick(3);
    chk("alarm irq", 32'h1, {31'h0, irq});
    rd(OFF_STATUS, rv);
    chk("alarm flag", 32'h3, rv);
    $display("test alarm done");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_rate();
    t_status();
    t_alarm();
    conclude();
  end

  // Watchdog: the tests need well under 10000 core cycles
  initial
  begin
    #200_000;
    miscompares++;
    conclude();
  end
endmodule // tb_top
